// File: hdl/goac_regs.vh
`ifndef GOAC_REGS_VH
`define GOAC_REGS_VH
// ----------------------------------------
// mode encodings
// ----------------------------------------
`define GOAC_MODE_OFF 2'h0
`define GOAC_MODE_ONCE 2'h1
`define GOAC_MODE_CONT 2'h2
`define GOAC_MODE_STEP 2'h3
// ----------------------------------------
// channel selector encodings
// ----------------------------------------
`define GOAC_SEL_ALL 4'h0
`define GOAC_SEL_RED 4'h1
`define GOAC_SEL_GREEN 4'h2
`define GOAC_SEL_BLUE 4'h3
`define GOAC_SEL_Y 4'h4
`define GOAC_SEL_U 4'h5
`define GOAC_SEL_V 4'h6
`define GOAC_SEL_TAP1 4'h7
// ----------------------------------------
// reset values and scaling
// ----------------------------------------
`define GOAC_GAIN_RESET 16'h0100
`define GOAC_OFFSET_RESET 16'h0000
`define GOAC_OFFSET_PHYS_SHIFT 2
`endif

// File: hdl/goac_servo.v
`timescale 1ns/100ps
// ----------------------------------------
// one-step servo toward a target, reports convergence
// ----------------------------------------
module goac_servo #(
  parameter W = 16,
  parameter TOL = 2
) (
  input wire [W-1:0] current,
  input wire [W-1:0] target,
  output reg [W-1:0] stepped,
  output reg done
);
  always @* begin
    stepped = current;
    done = 1'b0;
    if ((current > target ? current - target : target - current) <= TOL) begin
      done = 1'b1;
    end else if (current < target) begin
      stepped = current + {{(W-1){1'b0}}, 1'b1};
    end else begin
      stepped = current - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // goac_servo

// File: hdl/goac_mode_seq.v
`timescale 1ns/100ps
`include "goac_regs.vh"
// ----------------------------------------
// off / once / continuous / step mode holder
// ----------------------------------------
module goac_mode_seq (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire modeWrite,
  input wire [1:0] modeIn,
  input wire converged,
  output reg [1:0] mode,
  output wire active
);
  assign active = (mode != `GOAC_MODE_OFF);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= `GOAC_MODE_OFF;
    end else if (ce) begin
      // a write wins: software intent overrides the self-clear
      if (modeWrite) begin
        mode <= modeIn;
      end else if (mode == `GOAC_MODE_ONCE && converged) begin
        mode <= `GOAC_MODE_OFF;
      end
    end
  end
endmodule // goac_mode_seq

// File: hdl/gain_offset_auto_control.v
`timescale 1ns/100ps
`include "goac_regs.vh"
// How it works
// - auto gain off keeps software gain
// - gain once adjusts, then self-clears to off
// - gain continuous keeps adjusting until rewritten
// - extra mode value selects step algorithm for auto gain only; other loops run it as continuous
// - gain matching drives channels to common value
// - gain matching off uses manual channel gains
// - gain matching once, then self-clears
// - gain matching continuous keeps re-matching
// - selector picks all, colour, YUV or tap
// - all-channel selection writes every channel
// - physical offset sets selected channel offset
// - integer offset sets same offset raw
// - integer and physical views read consistently
// - auto offset off keeps software offset
// - offset once adjusts, then self-clears
// - offset continuous keeps adjusting
// - offset matching drives channels together
// - offset matching off uses manual offsets
// - offset matching once, then self-clears
// - offset matching continuous keeps re-matching
// - physical gain sets selected channel gain
module gain_offset_auto_control #(
  parameter NCH = 10,
  parameter W = 16,
  parameter TOL = 2
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire sample,
  input wire [4*NCH*W/4-1:0] channelLevel,
  input wire [W-1:0] gainTarget,
  input wire [W-1:0] offsetTarget,
  input wire [3:0] gainSelect,
  input wire gainWrite,
  input wire [W-1:0] gainValue,
  input wire [3:0] offsetChannelSelect,
  input wire offsetPhysicalWrite,
  input wire [W-1:0] videoOffsetPhysicalValueIn,
  input wire offsetIntegerWrite,
  input wire [W-1:0] videoOffsetIntegerValueIn,
  input wire autoAmpModeWrite,
  input wire [1:0] autoAmpModeIn,
  input wire ampMatchModeWrite,
  input wire [1:0] ampMatchModeIn,
  input wire autoOffsetModeWrite,
  input wire [1:0] autoOffsetModeIn,
  input wire offsetMatchModeWrite,
  input wire [1:0] offsetMatchModeIn,
  output reg [1:0] autoAmplificationMode,
  output reg [1:0] amplificationChannelMatchMode,
  output reg [1:0] autoOffsetMode,
  output reg [1:0] offsetChannelMatchMode,
  output reg [W-1:0] gainReadback,
  output reg [W-1:0] videoOffsetPhysicalValue,
  output reg [W-1:0] videoOffsetIntegerValue,
  output reg [NCH*W-1:0] channelGain,
  output reg [NCH*W-1:0] channelOffset
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [W-1:0] gain [0:NCH-1];
  reg [W-1:0] offs [0:NCH-1];
  wire [1:0] ampMode;
  wire [1:0] ampMatch;
  wire [1:0] offMode;
  wire [1:0] offMatch;
  wire ampAct;
  wire ampMatchAct;
  wire offAct;
  wire offMatchAct;
  reg ampConv;
  reg ampMatchConv;
  reg offConv;
  reg offMatchConv;
  wire [NCH*W-1:0] gStep;
  wire [NCH*W-1:0] gMatchStep;
  wire [NCH*W-1:0] oStep;
  wire [NCH*W-1:0] oMatchStep;
  wire [NCH-1:0] gDone;
  wire [NCH-1:0] gMatchDone;
  wire [NCH-1:0] oDone;
  wire [NCH-1:0] oMatchDone;
  reg [W-1:0] offsetWriteValue;
  wire offsetWrite;
  integer i;
  // ----------------------------------------
  // selector decode
  // ----------------------------------------
  // channels 0..5 are red..V, 6.. are taps; selector code minus one
  function sel_hit;
    input [3:0] sel;
    input integer ch;
    begin
      sel_hit = (sel == `GOAC_SEL_ALL) || ({28'h0, sel} == ch + 1);
    end
  endfunction
  // step mode leaves channels alone until they drift past twice tolerance
  function far_off;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      far_off = ((a > b) ? (a - b) : (b - a)) > 2 * TOL;
    end
  endfunction
  function [3:0] sel_index;
    input [3:0] sel;
    begin
      if (sel == `GOAC_SEL_ALL) begin
        sel_index = 4'h0;
      end else begin
        sel_index = sel - 4'h1;
      end
    end
  endfunction
  // ----------------------------------------
  // mode sequencers
  // ----------------------------------------
  goac_mode_seq uAmp (
    .clk(clk), .rst(rst), .ce(ce), .modeWrite(autoAmpModeWrite),
    .modeIn(autoAmpModeIn), .converged(ampConv), .mode(ampMode), .active(ampAct)
  );
  goac_mode_seq uAmpMatch (
    .clk(clk), .rst(rst), .ce(ce), .modeWrite(ampMatchModeWrite),
    .modeIn(ampMatchModeIn), .converged(ampMatchConv), .mode(ampMatch),
    .active(ampMatchAct)
  );
  goac_mode_seq uOff (
    .clk(clk), .rst(rst), .ce(ce), .modeWrite(autoOffsetModeWrite),
    .modeIn(autoOffsetModeIn), .converged(offConv), .mode(offMode), .active(offAct)
  );
  goac_mode_seq uOffMatch (
    .clk(clk), .rst(rst), .ce(ce), .modeWrite(offsetMatchModeWrite),
    .modeIn(offsetMatchModeIn), .converged(offMatchConv), .mode(offMatch),
    .active(offMatchAct)
  );
  // ----------------------------------------
  // servos, one per channel per loop
  // ----------------------------------------
  // matching targets channel 0, so the loop has a fixed reference
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      goac_servo #(.W(W), .TOL(TOL)) uG (
        .current(channelLevel[g*W +: W]), .target(gainTarget),
        .stepped(gStep[g*W +: W]), .done(gDone[g])
      );
      goac_servo #(.W(W), .TOL(TOL)) uGm (
        .current(channelLevel[g*W +: W]), .target(channelLevel[W-1:0]),
        .stepped(gMatchStep[g*W +: W]), .done(gMatchDone[g])
      );
      goac_servo #(.W(W), .TOL(TOL)) uO (
        .current(channelLevel[g*W +: W]), .target(offsetTarget),
        .stepped(oStep[g*W +: W]), .done(oDone[g])
      );
      goac_servo #(.W(W), .TOL(TOL)) uOm (
        .current(channelLevel[g*W +: W]), .target(channelLevel[W-1:0]),
        .stepped(oMatchStep[g*W +: W]), .done(oMatchDone[g])
      );
    end
  endgenerate
  // ----------------------------------------
  // offset write path
  // ----------------------------------------
  // both views share one store; physical is integer times a fixed scale
  assign offsetWrite = offsetPhysicalWrite | offsetIntegerWrite;
  always @* begin
    if (offsetIntegerWrite) begin
      offsetWriteValue = videoOffsetIntegerValueIn;
    end else begin
      offsetWriteValue = videoOffsetPhysicalValueIn >> `GOAC_OFFSET_PHYS_SHIFT;
    end
  end
  // ----------------------------------------
  // channel stores
  // ----------------------------------------
  // level error is judged on the sensor feedback, not on the settings
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NCH; i = i + 1) begin
        gain[i] <= `GOAC_GAIN_RESET;
        offs[i] <= `GOAC_OFFSET_RESET;
      end
      ampConv <= 1'b0;
      ampMatchConv <= 1'b0;
      offConv <= 1'b0;
      offMatchConv <= 1'b0;
    end else if (ce) begin
      ampConv <= sample & ampAct & (&gDone);
      ampMatchConv <= sample & ampMatchAct & (&gMatchDone);
      offConv <= sample & offAct & (&oDone);
      offMatchConv <= sample & offMatchAct & (&oMatchDone);
      for (i = 0; i < NCH; i = i + 1) begin
        if (sample && ampAct && !gDone[i]) begin
          // step mode moves only channels further than twice tolerance
          if (ampMode != `GOAC_MODE_STEP || far_off(channelLevel[i*W +: W], gainTarget)) begin
            gain[i] <= gain[i] + gStep[i*W +: W] - channelLevel[i*W +: W];
          end
        end else if (sample && ampMatchAct && !gMatchDone[i] && i != 0) begin
          gain[i] <= gain[i] + gMatchStep[i*W +: W] - channelLevel[i*W +: W];
        end else if (gainWrite && !ampAct && sel_hit(gainSelect, i)) begin
          gain[i] <= gainValue;
        end
        if (sample && offAct && !oDone[i]) begin
          offs[i] <= offs[i] + oStep[i*W +: W] - channelLevel[i*W +: W];
        end else if (sample && offMatchAct && !oMatchDone[i] && i != 0) begin
          offs[i] <= offs[i] + oMatchStep[i*W +: W] - channelLevel[i*W +: W];
        end else if (offsetWrite && !offAct && sel_hit(offsetChannelSelect, i)) begin
          offs[i] <= offsetWriteValue;
        end
      end
    end
  end
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      autoAmplificationMode <= `GOAC_MODE_OFF;
      amplificationChannelMatchMode <= `GOAC_MODE_OFF;
      autoOffsetMode <= `GOAC_MODE_OFF;
      offsetChannelMatchMode <= `GOAC_MODE_OFF;
      gainReadback <= `GOAC_GAIN_RESET;
      videoOffsetPhysicalValue <= `GOAC_OFFSET_RESET;
      videoOffsetIntegerValue <= `GOAC_OFFSET_RESET;
      channelGain <= {NCH{`GOAC_GAIN_RESET}};
      channelOffset <= {NCH{`GOAC_OFFSET_RESET}};
    end else if (ce) begin
      autoAmplificationMode <= ampMode;
      amplificationChannelMatchMode <= ampMatch;
      autoOffsetMode <= offMode;
      offsetChannelMatchMode <= offMatch;
      gainReadback <= gain[sel_index(gainSelect)];
      videoOffsetIntegerValue <= offs[sel_index(offsetChannelSelect)];
      videoOffsetPhysicalValue <=
        offs[sel_index(offsetChannelSelect)] << `GOAC_OFFSET_PHYS_SHIFT;
      for (i = 0; i < NCH; i = i + 1) begin
        channelGain[i*W +: W] <= gain[i];
        channelOffset[i*W +: W] <= offs[i];
      end
    end
  end
endmodule // gain_offset_auto_control

// File: sim/goac_sensor_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// sensor front end: one sample every 4 cycles
// ----------------------------------------
module goac_sensor_model #(
  parameter NCH = 10,
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire settled,
  input wire [W-1:0] level,
  output reg sample,
  output reg [NCH*W-1:0] channelLevel
);
  reg [1:0] phase;
  integer i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      sample <= 1'b0;
      channelLevel <= {NCH*W{1'b0}};
    end else begin
      phase <= phase + 2'h1;
      sample <= (phase == 2'h3);
      // spread levels keep the matching loops from converging early
      for (i = 0; i < NCH; i = i + 1)
        channelLevel[i*W +: W] <= (phase != 2'h3) ? ~channelLevel[i*W +: W] :
          settled ? level : level + 16'h0010 * i[W-1:0];
    end
  end
endmodule // goac_sensor_model

// File: sim/goac_monitor.sv
`timescale 1ns/100ps
`include "goac_regs.vh"
module goac_monitor #(
  parameter NCH = 10,
  parameter W = 16,
  parameter TOL = 2
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire sample,
  input wire gainWrite,
  input wire [3:0] offsetChannelSelect,
  input wire offsetPhysicalWrite,
  input wire offsetIntegerWrite,
  input wire [W-1:0] videoOffsetIntegerValueIn,
  input wire autoAmpModeWrite,
  input wire [1:0] autoAmpModeIn,
  input wire autoOffsetModeWrite,
  input wire offsetMatchModeWrite,
  input wire [1:0] offsetMatchModeIn,
  input wire [1:0] autoAmplificationMode,
  input wire [1:0] amplificationChannelMatchMode,
  input wire [1:0] autoOffsetMode,
  input wire [1:0] offsetChannelMatchMode,
  input wire [W-1:0] videoOffsetPhysicalValue,
  input wire [W-1:0] videoOffsetIntegerValue,
  input wire [NCH*W-1:0] channelGain
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_amp_mode_echo: assert property (autoAmpModeWrite && ce ##1 ce |->
    ##1 autoAmplificationMode == $past(autoAmpModeIn, 2)) else $error("amp mode lost");
  a_omatch_echo: assert property (offsetMatchModeWrite && ce ##1 ce |->
    ##1 offsetChannelMatchMode == $past(offsetMatchModeIn, 2)) else $error("match mode lost");
  a_amp_cont_stay: assert property (autoAmplificationMode == `GOAC_MODE_CONT &&
    !$past(autoAmpModeWrite) |=> autoAmplificationMode == `GOAC_MODE_CONT) else $error("cont left");
  a_oauto_cont_stay: assert property (autoOffsetMode == `GOAC_MODE_CONT &&
    !$past(autoOffsetModeWrite) |=> autoOffsetMode == `GOAC_MODE_CONT) else $error("cont left");
  // readbacks lag the internal mode by one cycle, so gate on the later view
  a_gain_manual_hold: assert property ($past(autoAmplificationMode) == 2'h0 &&
    $past(amplificationChannelMatchMode) == 2'h0 && !$past(gainWrite, 2) |->
    $stable(channelGain)) else $error("gain moved");
  a_amp_once_clear: assert property ($past(autoAmplificationMode) == `GOAC_MODE_ONCE &&
    autoAmplificationMode == `GOAC_MODE_OFF |-> $past(sample, 2) || $past(sample, 3) ||
    $past(sample, 4) || $past(autoAmpModeWrite, 2)) else $error("once cleared early");
  a_offset_scale: assert property (videoOffsetPhysicalValue ==
    videoOffsetIntegerValue << `GOAC_OFFSET_PHYS_SHIFT) else $error("views differ");
  a_int_write_echo: assert property (offsetIntegerWrite && ce && autoOffsetMode == 2'h0 ##1
    autoOffsetMode == 2'h0 && offsetChannelMatchMode == 2'h0 && !offsetIntegerWrite &&
    !offsetPhysicalWrite && $stable(offsetChannelSelect) && ce |=>
    videoOffsetIntegerValue == $past(videoOffsetIntegerValueIn, 2)) else $error("offset lost");
  c_amp_once: cover property (autoAmplificationMode == `GOAC_MODE_ONCE ##1 autoAmplificationMode == 2'h0);
  c_off_cont: cover property (autoOffsetMode == `GOAC_MODE_CONT);
  c_int_write: cover property (offsetIntegerWrite);
endmodule // goac_monitor

bind gain_offset_auto_control goac_monitor #(.NCH(NCH), .W(W), .TOL(TOL)) i_mon (
  .clk(clk), .rst(rst), .ce(ce), .sample(sample), .gainWrite(gainWrite),
  .offsetChannelSelect(offsetChannelSelect), .offsetPhysicalWrite(offsetPhysicalWrite),
  .offsetIntegerWrite(offsetIntegerWrite), .videoOffsetIntegerValueIn(videoOffsetIntegerValueIn),
  .autoAmpModeWrite(autoAmpModeWrite), .autoAmpModeIn(autoAmpModeIn),
  .autoOffsetModeWrite(autoOffsetModeWrite), .offsetMatchModeWrite(offsetMatchModeWrite),
  .offsetMatchModeIn(offsetMatchModeIn), .autoAmplificationMode(autoAmplificationMode),
  .amplificationChannelMatchMode(amplificationChannelMatchMode), .autoOffsetMode(autoOffsetMode),
  .offsetChannelMatchMode(offsetChannelMatchMode),
  .videoOffsetPhysicalValue(videoOffsetPhysicalValue),
  .videoOffsetIntegerValue(videoOffsetIntegerValue), .channelGain(channelGain));

// File: sim/testbench.sv
`timescale 1ns/100ps
`include "goac_regs.vh"
module testbench;
  localparam NCH = 10;
  localparam W = 16;
  reg clk, rst, ce, settled, gainWrite, physWrite, intWrite;
  reg [3:0] gainSelect, offSel, modeWrite;
  reg [1:0] modeIn;
  reg [W-1:0] gainValue, physIn, intIn;
  wire sample;
  wire [NCH*W-1:0] channelLevel, channelGain, channelOffset;
  wire [1:0] ampMode, ampMatch, offMode, offMatch;
  wire [W-1:0] gainReadback, physOut, intOut;
  integer err_count, num_checks, cycles, k, n;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  goac_sensor_model #(.NCH(NCH), .W(W)) i_sensor (.clk(clk), .rst(rst), .settled(settled),
    .level(16'h0200), .sample(sample), .channelLevel(channelLevel));
  gain_offset_auto_control #(.NCH(NCH), .W(W), .TOL(2)) i_dut (.clk(clk), .rst(rst), .ce(ce),
    .sample(sample), .channelLevel(channelLevel), .gainTarget(16'h0200),
    .offsetTarget(16'h0200), .gainSelect(gainSelect), .gainWrite(gainWrite),
    .gainValue(gainValue), .offsetChannelSelect(offSel), .offsetPhysicalWrite(physWrite),
    .videoOffsetPhysicalValueIn(physIn), .offsetIntegerWrite(intWrite),
    .videoOffsetIntegerValueIn(intIn), .autoAmpModeWrite(modeWrite[0]),
    .autoAmpModeIn(modeIn), .ampMatchModeWrite(modeWrite[1]), .ampMatchModeIn(modeIn),
    .autoOffsetModeWrite(modeWrite[2]), .autoOffsetModeIn(modeIn),
    .offsetMatchModeWrite(modeWrite[3]), .offsetMatchModeIn(modeIn),
    .autoAmplificationMode(ampMode), .amplificationChannelMatchMode(ampMatch),
    .autoOffsetMode(offMode), .offsetChannelMatchMode(offMatch), .gainReadback(gainReadback),
    .videoOffsetPhysicalValue(physOut), .videoOffsetIntegerValue(intOut),
    .channelGain(channelGain), .channelOffset(channelOffset));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task tick(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask
  task check(input [W-1:0] got, input [W-1:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one-cycle strobe, then one more cycle for the readback to land
  task pulse(input integer s);
    begin
      case (s)
        0: gainWrite = 1'b1;
        1: intWrite = 1'b1;
        default: physWrite = 1'b1;
      endcase
      tick(1);
      {gainWrite, intWrite, physWrite} = 3'h0;
      tick(1);
    end
  endtask
  task set_mode(input integer m, input [1:0] v);
    begin
      modeIn = v;
      modeWrite[m] = 1'b1;
      tick(1);
      modeWrite[m] = 1'b0;
      tick(1);
    end
  endtask
  function [1:0] mode_of(input integer m);
    mode_of = m == 0 ? ampMode : m == 1 ? ampMatch : m == 2 ? offMode : offMatch;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_manual;
    begin
      gainValue = 16'h0234;
      pulse(0);
      check(gainReadback, 16'h0234);
      check(channelGain[(NCH-1)*W +: W], 16'h0234);
      gainSelect = `GOAC_SEL_TAP1;
      gainValue = 16'h0345;
      pulse(0);
      check(gainReadback, 16'h0345);
      intIn = 16'h0011;
      pulse(1);
      check(physOut, 16'h0044);
      check(channelOffset[(NCH-1)*W +: W], 16'h0011);
      offSel = `GOAC_SEL_TAP1;
      physIn = 16'h0088;
      pulse(2);
      check(intOut, 16'h0022);
      check(channelOffset[W-1:0], 16'h0011);
    end
  endtask
  task t_once;
    for (k = 0; k < 4; k = k + 1) begin
      settled = 1'b0;
      set_mode(k, `GOAC_MODE_ONCE);
      tick(20);
      check(mode_of(k), `GOAC_MODE_ONCE);
      settled = 1'b1;
      for (n = 0; n < 40 && mode_of(k) !== `GOAC_MODE_OFF; n = n + 1)
        tick(1);
      check(mode_of(k), `GOAC_MODE_OFF);
    end
  endtask
  task t_cont;
    for (k = 0; k < 4; k = k + 1) begin
      set_mode(k, `GOAC_MODE_CONT);
      tick(30);
      check(mode_of(k), `GOAC_MODE_CONT);
      set_mode(k, `GOAC_MODE_STEP);
      check(mode_of(k), `GOAC_MODE_STEP);
      set_mode(k, `GOAC_MODE_OFF);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // a hang costs at most this many cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t timeout", $time);
      stop_test;
    end
  end
  initial begin
    {err_count, num_checks, cycles} = 0;
    {rst, ce, settled, gainWrite, physWrite, intWrite} = 6'h30;
    {gainSelect, offSel, modeWrite, modeIn} = 14'h0;
    {gainValue, physIn, intIn} = 48'h0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    check(gainReadback, `GOAC_GAIN_RESET);
    t_manual;
    t_once;
    t_cont;
    stop_test;
  end
endmodule // testbench
